/* File: shared/tjs_consts.svh */
// constants of the track jump sequencer: codes, counts and reset values
`ifndef TJS_CONSTS_SVH
`define TJS_CONSTS_SVH

// ==========================================
// timing
`define TJS_CLK_PERIOD_NS 50
`define TJS_KICK_SHORT_US 233
`define TJS_KICK_LONG_US 466
`define TJS_BRAKE_MS 60
`define TJS_CNT_W 21

// ==========================================
// command codes
`define TJS_CMD_SCHEME_PREV 8'hA0
`define TJS_CMD_SCHEME_NEW 8'hA1
`define TJS_CMD_FORCE_OFF 8'h0F
`define TJS_CMD_RELEASE 8'h8F
`define TJS_CMD_HOLD_ON 8'h21
`define TJS_CMD_HOLD_OFF 8'h20
`define TJS_CMD_BRAKE_NONE 8'hF6
`define TJS_CMD_BRAKE_60 8'h7F
`define TJS_CMD_BRAKE_ONLY 8'h8C
`define TJS_CMD_CHECK_256 8'h16
`define TJS_CMD_IN_V1 8'h11
`define TJS_CMD_IN_V2 8'h12
`define TJS_CMD_IN_V3 8'h31
`define TJS_CMD_IN_V4 8'h52
`define TJS_CMD_IN_2 8'h10
`define TJS_CMD_IN_4 8'h13
`define TJS_CMD_IN_16 8'h14
`define TJS_CMD_IN_32 8'h30
`define TJS_CMD_IN_64 8'h15
`define TJS_CMD_IN_128 8'h17
`define TJS_CMD_OUT_V1 8'h19
`define TJS_CMD_OUT_V2 8'h1A
`define TJS_CMD_OUT_V3 8'h39
`define TJS_CMD_OUT_V4 8'h5A
`define TJS_CMD_OUT_2 8'h18
`define TJS_CMD_OUT_4 8'h1B
`define TJS_CMD_OUT_16 8'h1C
`define TJS_CMD_OUT_32 8'h38
`define TJS_CMD_OUT_64 8'h1D
`define TJS_CMD_OUT_128 8'h1F
`define TJS_DIR_BIT 3

// ==========================================
// period lengths in error-sign edges, two edges per track crossing
`define TJS_E_HALF 21'h000001
`define TJS_E_1 21'h000002
`define TJS_E_2 21'h000004
`define TJS_E_7 21'h00000E
`define TJS_E_9 21'h000012
`define TJS_E_14 21'h00001C
`define TJS_E_18 21'h000024
`define TJS_E_28 21'h000038
`define TJS_E_36 21'h000048
`define TJS_E_56 21'h000070
`define TJS_E_72 21'h000090
`define TJS_E_256 21'h000200

// ==========================================
// reset values
`define TJS_RST_SCHEME_NEW 1'b0
`define TJS_RST_FORCE_OFF 1'b0
`define TJS_RST_HOLD_MODE 1'b0
`define TJS_RST_BRAKE_EN 1'b0
`define TJS_RST_CMD 8'h00

`endif

/* File: shared/tjs_pkg.sv */
// types of the track jump sequencer
package tjs_pkg;
`include "tjs_consts.svh"

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ACCEL = 3'h1,
		ST_DECEL = 3'h2,
		ST_CHECK = 3'h3,
		ST_BRAKE = 3'h4
	} tjs_state_t;

	typedef struct packed {
		logic ok;
		logic dir_out;
		logic a_timed;
		logic b_timed;
		logic [`TJS_CNT_W-1:0] a_len;
		logic [`TJS_CNT_W-1:0] b_len;
		logic has_c;
		logic c_tracking_off_out_low;
		logic check;
		logic brake_only;
	} tjs_plan_t;

	typedef struct packed {
		tjs_state_t state;
		tjs_plan_t plan;
		logic [`TJS_CNT_W-1:0] cnt;
		logic timed;
		logic [7:0] cmd;
		logic scheme_new;
		logic force_off;
		logic hold_mode;
		logic brake_en;
		logic tes_prev;
		logic brake_tracking_off_out;
		logic fwd;
		logic rev;
		logic tracking_off_out;
		logic gain;
		logic busy;
	} tjs_regs_t;

endpackage

/* File: src/tjs_sequencer.sv */
// track jump sequencer: command decode, period timing and braking control
//
// Overview of operation
// - jump runs acceleration, deceleration, then braking
// - braking tracking-off follows slip from sign, mirror
// - gain toggle raised during braking
// - hold mode forces tracking-off while hold high
// - tracking-off low only in constant velocity mode
// - force/release tracking-off, only in constant velocity
// - two timing schemes, previous is reset default
// - variant 1: 233 us, 233 us, 60 ms
// - variant 2: half crossing accel, scheme-dependent decel
// - variant 3: as variant 2, no braking
// - variant 4: braking with tracking-off held low
// - two-track jump, new scheme, no braking
// - four-track: 2 crossings, 466 us or 2
// - sixteen-track: 9 crossings, 7 or 9
// - 32/64/128 track crossing counts, then braking
// - 256 check: no pulses, tracking-off high, braking
// - brake command performs braking interval only
// - braking presence selectable, none after reset
// - command register clears when sequence finishes
// - new jump command aborts and restarts at once
`timescale 1ns/1ps
`include "tjs_consts.svh"

module tjs_sequencer #(
	parameter int T233_CYC = (`TJS_KICK_SHORT_US * 1000) / `TJS_CLK_PERIOD_NS,
	parameter int T466_CYC = (`TJS_KICK_LONG_US * 1000) / `TJS_CLK_PERIOD_NS,
	parameter int BRAKE_CYC = (`TJS_BRAKE_MS * 1000000) / `TJS_CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// servo command from the serial port, same clock
	input wire logic [7:0] cmd_i,
	input wire logic cmd_valid_i,
	// disc motor state, same clock
	input wire logic constant_linear_velocity_mode_i,
	// tracking pins, asynchronous
	input wire logic track_error_sign_in_i,
	input wire logic mirror_detect_in_i,
	input wire logic hold_period_in_i,
	// actuator and servo outputs
	output logic jump_actuator_out_fwd_o,
	output logic jump_actuator_out_rev_o,
	output logic tracking_off_out_o,
	output logic gain_toggle_out_o,
	// status
	output logic busy_o,
	output logic [7:0] servo_cmd_o,
	output logic scheme_new_o,
	output logic brake_en_o
);

	// ==========================================
	// constants and state

	localparam logic [`TJS_CNT_W-1:0] T233 = T233_CYC[`TJS_CNT_W-1:0];
	localparam logic [`TJS_CNT_W-1:0] T466 = T466_CYC[`TJS_CNT_W-1:0];
	localparam logic [`TJS_CNT_W-1:0] TBRK = BRAKE_CYC[`TJS_CNT_W-1:0];
	localparam logic [`TJS_CNT_W-1:0] CNT_ONE = `TJS_CNT_W'(1);

	tjs_pkg::tjs_regs_t q;
	tjs_pkg::tjs_regs_t d;
	tjs_pkg::tjs_plan_t plan;
	logic [2:0] pins_s;
	logic tes_s;
	logic hfl_s;
	logic hold_s;
	logic tes_edge;
	logic tick;
	logic last;

	// ==========================================
	// pin synchronisers

	tjs_sync #(
		.W(3)
	) u_sync (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.pin_i({track_error_sign_in_i, mirror_detect_in_i, hold_period_in_i}),
		.sync_o(pins_s)
	);

	assign tes_s = pins_s[2];
	assign hfl_s = pins_s[1];
	assign hold_s = pins_s[0];

	// ==========================================
	// command decode into a jump plan

	function automatic tjs_pkg::tjs_plan_t decode(
		input logic [7:0] c,
		input logic sn,
		input logic be
	);
		tjs_pkg::tjs_plan_t p;
		p = '0;
		p.ok = 1'b1;
		p.dir_out = c[`TJS_DIR_BIT];
		p.has_c = be;
		p.a_len = `TJS_E_HALF;
		p.b_len = sn ? `TJS_E_HALF : T233;
		p.b_timed = !sn;
		unique case (c)
			`TJS_CMD_IN_V1, `TJS_CMD_OUT_V1:
			begin
				p.a_timed = 1'b1;
				p.a_len = T233;
				p.b_timed = 1'b1;
				p.b_len = T233;
			end
			`TJS_CMD_IN_V2, `TJS_CMD_OUT_V2:
			begin
				p.a_timed = 1'b0;
			end
			`TJS_CMD_IN_V3, `TJS_CMD_OUT_V3:
			begin
				p.has_c = 1'b0;
			end
			`TJS_CMD_IN_V4, `TJS_CMD_OUT_V4:
			begin
				p.c_tracking_off_out_low = 1'b1;
			end
			`TJS_CMD_IN_2, `TJS_CMD_OUT_2:
			begin
				p.ok = sn;
				p.a_len = `TJS_E_1;
				p.b_timed = 1'b0;
				p.b_len = `TJS_E_1;
				p.has_c = 1'b0;
			end
			`TJS_CMD_IN_4, `TJS_CMD_OUT_4:
			begin
				p.a_len = `TJS_E_2;
				p.b_len = sn ? `TJS_E_2 : T466;
			end
			`TJS_CMD_IN_16, `TJS_CMD_OUT_16:
			begin
				p.a_len = `TJS_E_9;
				p.b_timed = 1'b0;
				p.b_len = sn ? `TJS_E_9 : `TJS_E_7;
			end
			`TJS_CMD_IN_32, `TJS_CMD_OUT_32:
			begin
				p.a_len = `TJS_E_18;
				p.b_timed = 1'b0;
				p.b_len = `TJS_E_14;
			end
			`TJS_CMD_IN_64, `TJS_CMD_OUT_64:
			begin
				p.a_len = `TJS_E_36;
				p.b_timed = 1'b0;
				p.b_len = `TJS_E_28;
			end
			`TJS_CMD_IN_128, `TJS_CMD_OUT_128:
			begin
				p.a_len = `TJS_E_72;
				p.b_timed = 1'b0;
				p.b_len = `TJS_E_56;
			end
			`TJS_CMD_CHECK_256:
			begin
				p.check = 1'b1;
				p.dir_out = 1'b0;
				p.a_len = `TJS_E_256;
			end
			`TJS_CMD_BRAKE_ONLY:
			begin
				p.brake_only = 1'b1;
				p.dir_out = 1'b0;
				p.has_c = 1'b1;
			end
			default:
			begin
				p = '0;
			end
		endcase
		return p;
	endfunction

	// ==========================================
	// sequencing

	always_comb
	begin
		d = q;
		plan = decode(cmd_i, q.scheme_new, q.brake_en);
		tes_edge = tes_s ^ q.tes_prev;
		d.tes_prev = tes_s;
		// timed periods count clocks, crossing periods count sign edges
		tick = q.timed | tes_edge;
		last = tick && (q.cnt == CNT_ONE);
		if (tick && (q.cnt != '0))
		begin
			d.cnt = q.cnt - CNT_ONE;
		end
		// slip direction is taken from the mirror level at each sign edge
		if ((q.state == tjs_pkg::ST_BRAKE) && tes_edge)
		begin
			d.brake_tracking_off_out = hfl_s;
		end
		unique case (q.state)
			tjs_pkg::ST_IDLE:
			begin
				d.cnt = '0;
			end
			tjs_pkg::ST_ACCEL:
			begin
				if (last)
				begin
					d.state = tjs_pkg::ST_DECEL;
					d.cnt = q.plan.b_len;
					d.timed = q.plan.b_timed;
				end
			end
			tjs_pkg::ST_DECEL, tjs_pkg::ST_CHECK:
			begin
				if (last && q.plan.has_c)
				begin
					d.state = tjs_pkg::ST_BRAKE;
					d.cnt = TBRK;
					d.timed = 1'b1;
					d.brake_tracking_off_out = 1'b1;
				end
				else if (last)
				begin
					// without braking the outside servo must catch the track
					d.state = tjs_pkg::ST_IDLE;
					d.cmd = `TJS_RST_CMD;
				end
			end
			tjs_pkg::ST_BRAKE:
			begin
				if (last)
				begin
					d.state = tjs_pkg::ST_IDLE;
					d.cmd = `TJS_RST_CMD;
				end
			end
			default:
			begin
				d.state = tjs_pkg::ST_IDLE;
			end
		endcase
		if (cmd_valid_i)
		begin
			unique case (cmd_i)
				`TJS_CMD_SCHEME_PREV: d.scheme_new = 1'b0;
				`TJS_CMD_SCHEME_NEW: d.scheme_new = 1'b1;
				`TJS_CMD_HOLD_ON: d.hold_mode = 1'b1;
				`TJS_CMD_HOLD_OFF: d.hold_mode = 1'b0;
				`TJS_CMD_BRAKE_NONE: d.brake_en = 1'b0;
				`TJS_CMD_BRAKE_60: d.brake_en = 1'b1;
				`TJS_CMD_FORCE_OFF:
				begin
					if (constant_linear_velocity_mode_i)
					begin
						d.force_off = 1'b1;
					end
				end
				`TJS_CMD_RELEASE:
				begin
					if (constant_linear_velocity_mode_i)
					begin
						d.force_off = 1'b0;
					end
				end
				default:
				begin
					// a jump restarts even over one already running
					if (plan.ok)
					begin
						d.plan = plan;
						d.cmd = cmd_i;
						d.brake_tracking_off_out = 1'b1;
						if (plan.brake_only)
						begin
							d.state = tjs_pkg::ST_BRAKE;
							d.cnt = TBRK;
							d.timed = 1'b1;
						end
						else if (plan.check)
						begin
							d.state = tjs_pkg::ST_CHECK;
							d.cnt = plan.a_len;
							d.timed = 1'b0;
						end
						else
						begin
							d.state = tjs_pkg::ST_ACCEL;
							d.cnt = plan.a_len;
							d.timed = plan.a_timed;
						end
					end
				end
			endcase
		end
		// ==========================================
		// outputs, registered from the next state
		d.fwd = (d.state == tjs_pkg::ST_ACCEL) ? !d.plan.dir_out
			: (d.state == tjs_pkg::ST_DECEL) && d.plan.dir_out;
		d.rev = (d.state == tjs_pkg::ST_ACCEL) ? d.plan.dir_out
			: (d.state == tjs_pkg::ST_DECEL) && !d.plan.dir_out;
		d.gain = (d.state == tjs_pkg::ST_BRAKE);
		d.busy = (d.state != tjs_pkg::ST_IDLE);
		if (!constant_linear_velocity_mode_i)
		begin
			d.tracking_off_out = 1'b1;
		end
		else if (d.force_off)
		begin
			d.tracking_off_out = 1'b1;
		end
		else if (d.hold_mode && hold_s)
		begin
			d.tracking_off_out = 1'b1;
		end
		else if (d.state == tjs_pkg::ST_CHECK)
		begin
			// loop stays open; the controller drives the feed motor
			d.tracking_off_out = 1'b1;
		end
		else if (d.state == tjs_pkg::ST_BRAKE)
		begin
			d.tracking_off_out = d.plan.c_tracking_off_out_low ? 1'b0 : d.brake_tracking_off_out;
		end
		else
		begin
			d.tracking_off_out = 1'b0;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			q <= '0;
			q.state <= tjs_pkg::ST_IDLE;
			q.cmd <= `TJS_RST_CMD;
			q.scheme_new <= `TJS_RST_SCHEME_NEW;
			q.force_off <= `TJS_RST_FORCE_OFF;
			q.hold_mode <= `TJS_RST_HOLD_MODE;
			q.brake_en <= `TJS_RST_BRAKE_EN;
			// disc motor is stopped after reset, so tracking is off
			q.tracking_off_out <= 1'b1;
			q.brake_tracking_off_out <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	// ==========================================
	// ports

	assign jump_actuator_out_fwd_o = q.fwd;
	assign jump_actuator_out_rev_o = q.rev;
	assign tracking_off_out_o = q.tracking_off_out;
	assign gain_toggle_out_o = q.gain;
	assign busy_o = q.busy;
	assign servo_cmd_o = q.cmd;
	assign scheme_new_o = q.scheme_new;
	assign brake_en_o = q.brake_en;

endmodule // tjs_sequencer

/* File: src/tjs_sync.sv */
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps

module tjs_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// pins and synchronised copies
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} tjs_sync_regs_t;

	tjs_sync_regs_t q;
	tjs_sync_regs_t d;

	always_comb
	begin
		d = q;
		d.s1 = pin_i;
		d.s2 = q.s1;
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign sync_o = q.s2;

endmodule // tjs_sync

/* File: tb/tb_top.sv */
// testbench of the track jump sequencer
`timescale 1ns/1ps

module tb_top;
	// ==========================================
	// signals
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] cmd_i = 8'h00;
	logic cmd_valid_i = 1'b0;
	logic constant_linear_velocity_mode = 1'b0;
	logic hold = 1'b0;
	logic sign;
	logic mirror;
	logic fwd;
	logic rev;
	logic tracking_off_out;
	logic gain;
	logic busy;
	logic [7:0] scmd;
	logic snew;
	logic ben;
	int err_total = 0;
	int checked = 0;
	int cnt [5];
	always #25 clock_i = !clock_i;

	// short counts keep the run brief; expectations follow them
	tjs_sequencer #(.T233_CYC(8), .T466_CYC(16), .BRAKE_CYC(40)) i_tjs_sequencer (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.cmd_i(cmd_i),
		.cmd_valid_i(cmd_valid_i),
		.constant_linear_velocity_mode_i(constant_linear_velocity_mode),
		.track_error_sign_in_i(sign),
		.mirror_detect_in_i(mirror),
		.hold_period_in_i(hold),
		.jump_actuator_out_fwd_o(fwd),
		.jump_actuator_out_rev_o(rev),
		.tracking_off_out_o(tracking_off_out),
		.gain_toggle_out_o(gain),
		.busy_o(busy),
		.servo_cmd_o(scmd),
		.scheme_new_o(snew),
		.brake_en_o(ben)
	);
	// one sign edge every 6 cycles, so n edges span 6n cycles
	tjs_servo_model #(.HALF(6)) i_tjs_servo_model (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.sign_o(sign),
		.mirror_o(mirror)
	);

	// ==========================================
	// shared tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clock_i);
	endtask

	task automatic send(input logic [7:0] c);
		@(posedge clock_i);
		cmd_i <= c;
		cmd_valid_i <= 1'b1;
		@(posedge clock_i);
		cmd_valid_i <= 1'b0;
	endtask

	// counts: fwd, rev, gain, tracking off in braking, tracking on outside braking
	task automatic jump(input logic [7:0] c);
		int n;
		cnt = '{default: 0};
		send(c);
		for (n = 0; n < 5000; n++)
		begin
			@(negedge clock_i);
			if (busy !== 1'b1)
				break;
			cnt[0] += int'(fwd);
			cnt[1] += int'(rev);
			cnt[2] += int'(gain);
			cnt[3] += int'(tracking_off_out && gain);
			cnt[4] += int'(!gain && !tracking_off_out);
		end
		// a sequence that never ends runs out the loop and fails here
		chk(busy, 1'b0);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset;
		repeat (10) @(posedge clock_i);
		reset_i <= 1'b0;
		idle(1);
		chk(busy, 1'b0);
		chk(scmd, 8'h00);
		chk(snew, 1'b0);
		chk(ben, 1'b0);
		chk(tracking_off_out, 1'b1);
		$display("end reset");
	endtask

	task automatic t_tracking_off_out;
		@(posedge clock_i);
		constant_linear_velocity_mode <= 1'b1;
		idle(2);
		chk(tracking_off_out, 1'b0);
		send(8'h0F);
		idle(1);
		chk(tracking_off_out, 1'b1);
		@(posedge clock_i);
		constant_linear_velocity_mode <= 1'b0;
		send(8'h8F);
		@(posedge clock_i);
		constant_linear_velocity_mode <= 1'b1;
		idle(2);
		chk(tracking_off_out, 1'b1);
		send(8'h8F);
		idle(1);
		chk(tracking_off_out, 1'b0);
		send(8'h21);
		@(posedge clock_i);
		hold <= 1'b1;
		idle(4);
		chk(tracking_off_out, 1'b1);
		send(8'h20);
		idle(1);
		chk(tracking_off_out, 1'b0);
		@(posedge clock_i);
		hold <= 1'b0;
		$display("end tracking off");
	endtask

	task automatic t_prev;
		send(8'h7F);
		idle(1);
		chk(ben, 1'b1);
		jump(8'h11);
		chk(cnt[0], 32'h8);
		chk(cnt[1], 32'h8);
		chk(cnt[2], 32'h28);
		chk(cnt[3] inside {[32'h1:32'h27]}, 1'b1);
		jump(8'h52);
		chk(cnt[1], 32'h8);
		chk(cnt[2], 32'h28);
		chk(cnt[3], 32'h0);
		jump(8'h31);
		chk(cnt[2], 32'h0);
		jump(8'h10);
		chk(cnt[0], 32'h0);
		jump(8'h13);
		chk(cnt[1], 32'h10);
		jump(8'h1C);
		chk(cnt[0], 32'h54);
		jump(8'h15);
		chk(cnt[1], 32'h150);
		$display("end previous scheme");
	endtask

	task automatic t_new;
		send(8'hA1);
		idle(1);
		chk(snew, 1'b1);
		jump(8'h12);
		chk(cnt[1], 32'h6);
		jump(8'h10);
		chk(cnt[1], 32'hC);
		chk(cnt[2], 32'h0);
		jump(8'h13);
		chk(cnt[1], 32'h18);
		jump(8'h14);
		chk(cnt[1], 32'h6C);
		jump(8'h38);
		chk(cnt[0], 32'hA8);
		send(8'hA0);
		idle(1);
		chk(snew, 1'b0);
		$display("end new scheme");
	endtask

	task automatic t_check;
		jump(8'h16);
		chk(cnt[0] + cnt[1], 32'h0);
		chk(cnt[4], 32'h0);
		chk(cnt[2], 32'h28);
		$display("end track check");
	endtask

	task automatic t_brake;
		send(8'hF6);
		idle(1);
		chk(ben, 1'b0);
		jump(8'h8C);
		chk(cnt[2], 32'h28);
		chk(cnt[0] + cnt[1], 32'h0);
		jump(8'h11);
		chk(cnt[2], 32'h0);
		$display("end brake");
	endtask

	task automatic t_abort;
		send(8'h17);
		idle(30);
		chk(busy, 1'b1);
		jump(8'h1A);
		chk(cnt[0], 32'h8);
		chk(scmd, 8'h00);
		$display("end abort");
	endtask

	task automatic t_codes;
		jump(8'h19);
		chk(cnt[1], 32'h8);
		chk(cnt[0], 32'h8);
		chk(cnt[2], 32'h0);
		jump(8'h39);
		chk(cnt[0], 32'h8);
		send(8'h7F);
		jump(8'h5A);
		chk(cnt[0], 32'h8);
		chk(cnt[3], 32'h0);
		chk(cnt[2], 32'h28);
		jump(8'h1B);
		chk(cnt[0], 32'h10);
		jump(8'h30);
		chk(cnt[1], 32'hA8);
		jump(8'h1D);
		chk(cnt[0], 32'h150);
		jump(8'h1F);
		chk(cnt[0], 32'h2A0);
		send(8'hA1);
		jump(8'h18);
		chk(cnt[0], 32'hC);
		chk(cnt[2], 32'h0);
		send(8'hA0);
		$display("end other codes");
	endtask

	// ==========================================
	// main sequence and watchdog
	initial
	begin
		t_reset;
		t_tracking_off_out;
		t_prev;
		t_new;
		t_check;
		t_brake;
		t_abort;
		t_codes;
		test_done;
	end

	// the tests need about 8400 cycles; cut a hang after 40000
	initial
	begin
		#2000000;
		err_total++;
		test_done;
	end
endmodule // tb_top

/* File: tb/tjs_sequencer_assertions.sv */
// concurrent checks on the ports of the track jump sequencer
`timescale 1ns/1ps

module tjs_sequencer_assertions #(
	parameter int T233_CYC = 4660,
	parameter int BRAKE_CYC = 1200000
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// command and motor state
	input wire logic [7:0] cmd_i,
	input wire logic cmd_valid_i,
	input wire logic constant_linear_velocity_mode_i,
	// outputs under watch
	input wire logic jump_actuator_out_fwd_o,
	input wire logic jump_actuator_out_rev_o,
	input wire logic tracking_off_out_o,
	input wire logic gain_toggle_out_o,
	input wire logic busy_o,
	input wire logic [7:0] servo_cmd_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	// ==========================================
	// run lengths, cleared when the output drops
	logic [31:0] fwd_len_q;
	logic [31:0] gain_len_q;
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			fwd_len_q <= 32'h0;
			gain_len_q <= 32'h0;
		end
		else
		begin
			fwd_len_q <= jump_actuator_out_fwd_o ? fwd_len_q + 32'h1 : 32'h0;
			gain_len_q <= gain_toggle_out_o ? gain_len_q + 32'h1 : 32'h0;
		end
	end

	// ==========================================
	// properties
	idle_cmd_a: assert property (!busy_o |-> servo_cmd_o == 8'h00)
		else $error("command code kept while idle");
	kick_excl_a: assert property (!(jump_actuator_out_fwd_o && jump_actuator_out_rev_o))
		else $error("both kicks high");
	kick_idle_a: assert property ((jump_actuator_out_fwd_o || jump_actuator_out_rev_o) |->
		busy_o && !gain_toggle_out_o) else $error("kick outside a jump");
	tracking_off_out_clv_a: assert property (!constant_linear_velocity_mode_i |=> tracking_off_out_o)
		else $error("tracking off low outside velocity mode");
	force_off_a: assert property (cmd_valid_i && cmd_i == 8'h0F &&
		constant_linear_velocity_mode_i ##1 constant_linear_velocity_mode_i |-> tracking_off_out_o)
		else $error("forced tracking off not high");
	start_in_a: assert property (cmd_valid_i && cmd_i == 8'h11 |=> jump_actuator_out_fwd_o &&
		busy_o && servo_cmd_o == 8'h11) else $error("inward jump did not start");
	check_quiet_a: assert property (servo_cmd_o == 8'h16 && !gain_toggle_out_o |->
		tracking_off_out_o && !jump_actuator_out_fwd_o && !jump_actuator_out_rev_o)
		else $error("track check not quiet");
	kick_len_a: assert property ($fell(jump_actuator_out_fwd_o) && servo_cmd_o == 8'h11 |->
		fwd_len_q == T233_CYC && jump_actuator_out_rev_o) else $error("short kick length wrong");
	brake_len_a: assert property ($fell(gain_toggle_out_o) && !busy_o |->
		gain_len_q == BRAKE_CYC) else $error("braking length wrong");
endmodule // tjs_sequencer_assertions

bind tjs_sequencer tjs_sequencer_assertions #(
	.T233_CYC(T233_CYC),
	.BRAKE_CYC(BRAKE_CYC)
) i_tjs_sequencer_assertions (
	.clock_i(clock_i),
	.reset_i(reset_i),
	.cmd_i(cmd_i),
	.cmd_valid_i(cmd_valid_i),
	.constant_linear_velocity_mode_i(constant_linear_velocity_mode_i),
	.jump_actuator_out_fwd_o(jump_actuator_out_fwd_o),
	.jump_actuator_out_rev_o(jump_actuator_out_rev_o),
	.tracking_off_out_o(tracking_off_out_o),
	.gain_toggle_out_o(gain_toggle_out_o),
	.busy_o(busy_o),
	.servo_cmd_o(servo_cmd_o)
);

/* File: tb/tjs_servo_model.sv */
// servo front-end model: error sign and mirror detect of a beam crossing tracks
`timescale 1ns/1ps

module tjs_servo_model #(
	parameter int HALF = 6
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// pins towards the sequencer
	output logic sign_o,
	output logic mirror_o
);
	// ==========================================
	// steady crossing rate; braking and feed stay with the controller side
	int cnt_q;
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cnt_q <= 0;
			sign_o <= 1'b0;
			mirror_o <= 1'b0;
		end
		else
		begin
			// crossings go on without kicks: feed motion or outside braking moves the beam
			cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
			if (cnt_q == HALF - 1)
				sign_o <= !sign_o;
			// offset to toggle two cycles before each sign edge so mirror alternates from one sign edge to the next
			if (cnt_q == HALF / 2)
				mirror_o <= !mirror_o;
		end
	end
endmodule // tjs_servo_model
